// file: rtl/flash_status_params.svh
// Behaviour
// - opcode 15h streams third status byte, MSB first
// - after bit 0, restart at bit 7
// - each repetition carries freshly sampled status
// - chip select high ends read, output released
// - bits 6:5 output strength, reset 11
// - status write changes only writable bits
// - locks 00: writable whenever write latch set
// - locks 01, protect pin low: writes refused
// - locks 01, protect pin high: writable with latch
// - locks 10: writes blocked until power cycle
// - power cycle returns locks to 00
// - invert, granularity, top/bottom, three amount bits
// - latch clear: program, erase, status writes ignored
// - write latch reads 0 after reset
// - latch cleared on disable, completion or abort
// - partial opcode leaves latch set
// - abort clears latch only after full opcode
// - busy set throughout internal operation
// - busy is first status byte bit 0
// - write latch is first status byte bit 1
// - lock hi: byte2 bit0; lock lo: byte1 bit7
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH
`define OPC_WR_ENABLE 8'h06
`define OPC_WR_DISABLE 8'h04
`define OPC_RD_STAT1 8'h05
`define OPC_RD_STAT2 8'h35
`define OPC_RD_STAT3 8'h15
`define OPC_WR_STAT1 8'h01
`define OPC_WR_STAT2 8'h31
`define OPC_WR_STAT3 8'h11
`define OPC_PAGE_PROG 8'h02
`define OPC_SEC_PROG 8'h42
`define OPC_SEC_ERASE 8'h44
`define OPC_ERASE_4K 8'h20
`define OPC_ERASE_32K 8'h52
`define OPC_ERASE_64K 8'hd8
`define OPC_CHIP_ERASE1 8'h60
`define OPC_CHIP_ERASE2 8'hc7
`define STAT2_RW_MASK 8'h7b
`define STAT3_RW_MASK 8'hff
`define STAT3_RESET 8'h60
`define STAT2_LOCK_HI_BIT 0
`define STAT2_INVERT_BIT 6
`define STAT3_STRENGTH_LSB 5
`define ADDR_BYTES 3'd3
`define WRSTAT_BUSY_CYCLES 16
`define PROG_BUSY_CYCLES 64
`endif

// file: rtl/flash_status_pkg.sv
package flash_status_pkg;
  // synchronised view of the serial pins
  typedef struct packed {
    logic cs_b;
    logic sck;
    logic si;
    logic wp_b;
  } spi_pins_t;
  // array protection setting
  typedef struct packed {
    logic protect_invert;
    logic protect_granularity_sel;
    logic protect_top_bottom_sel;
    logic [2:0] protect_amount;
  } protect_t;
  // frame decoder states
  typedef enum logic [2:0] {
    ST_OPCODE, ST_READ, ST_WRSTAT, ST_PROG, ST_ERASE, ST_CHIPER, ST_IGNORE
  } frame_state_t;
endpackage

// file: rtl/flash_status_protect_regs.sv
`include "flash_status_params.svh"
module flash_status_protect_regs
  import flash_status_pkg::*;
#(
  parameter int WRSTAT_CYCLES = `WRSTAT_BUSY_CYCLES,
  parameter int PROG_CYCLES = `PROG_BUSY_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire spi_pins_t pins,
  output logic so,
  output logic so_oe,
  output logic write_latch,
  output logic op_in_progress,
  output logic [1:0] output_strength,
  output logic status_lock_hi,
  output logic status_lock_lo,
  output protect_t protect
);
  spi_pins_t meta_reg; // first stage, read only by sync_reg
  spi_pins_t sync_reg; // second stage
  logic sck_d; // previous synced clock
  logic cs_d; // previous synced select
  frame_state_t state_reg;
  frame_state_t state_next;
  logic [7:0] shift_reg; // incoming serial bits
  logic [2:0] bit_cnt; // bits of current byte
  logic [2:0] byte_cnt; // bytes after opcode, saturating
  logic [7:0] data0_reg; // first data byte of a status write
  logic [7:0] data1_reg; // second data byte
  logic [7:0] wr_opc_reg; // opcode of pending status write
  logic [1:0] rd_sel_reg; // which status byte is streamed
  logic [2:0] out_idx; // next bit to present
  logic [7:0] snap_reg; // byte captured at each bit 7
  logic [5:0] stat1_reg; // writable part of byte 1
  logic [7:0] stat2_reg;
  logic [7:0] stat3_reg;
  logic [15:0] busy_cnt;
  logic busy_from_prog; // running op ends with latch clear
  logic rise, fall, cs_rise, byte_done;
  logic [7:0] byte_in;
  logic [7:0] stat1_view, stat_view;
  logic frame_ok, wr_allowed, busy_start;
  logic [15:0] busy_len;
  logic [1:0] locks;

  // two-flop synchroniser on every pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b0};
      sync_reg <= '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b0};
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      sck_d <= sync_reg.sck;
      cs_d <= sync_reg.cs_b;
    end
  end

  // edges of the link clock seen only while selected
  assign rise = !sync_reg.cs_b && sync_reg.sck && !sck_d;
  assign fall = !sync_reg.cs_b && !sync_reg.sck && sck_d;
  assign cs_rise = sync_reg.cs_b && !cs_d;
  assign byte_done = rise && (bit_cnt == 3'd7);
  assign byte_in = {shift_reg[6:0], sync_reg.si};
  assign locks = {status_lock_hi, status_lock_lo};

  // live status bytes, sampled again at every repetition
  assign stat1_view = {stat1_reg, write_latch, op_in_progress};
  always_comb begin
    unique case (rd_sel_reg)
      2'd1: stat_view = stat1_view;
      2'd2: stat_view = stat2_reg;
      default: stat_view = stat3_reg;
    endcase
  end

  // status writes only when the lock state allows it
  always_comb begin
    unique case (locks)
      2'b00: wr_allowed = 1'b1;
      2'b01: wr_allowed = sync_reg.wp_b;
      default: wr_allowed = 1'b0;
    endcase
  end

  // a frame counts only if it ended on a byte edge with its bytes
  always_comb begin
    frame_ok = 1'b0;
    if (bit_cnt == 3'd0) begin
      unique case (state_reg)
        ST_WRSTAT: frame_ok = (byte_cnt == 3'd1) ||
            ((byte_cnt == 3'd2) && (wr_opc_reg == `OPC_WR_STAT1));
        ST_PROG: frame_ok = byte_cnt > `ADDR_BYTES;
        ST_ERASE: frame_ok = byte_cnt == `ADDR_BYTES;
        ST_CHIPER: frame_ok = byte_cnt == 3'd0;
        default: frame_ok = 1'b0;
      endcase
    end
  end
  assign busy_start = cs_rise && frame_ok;
  assign busy_len = (state_reg == ST_WRSTAT) ? 16'(WRSTAT_CYCLES) : 16'(PROG_CYCLES);

  // opcode decode at the eighth bit
  always_comb begin
    state_next = state_reg;
    if (byte_done && state_reg == ST_OPCODE) begin
      state_next = ST_IGNORE;
      unique case (byte_in)
        `OPC_RD_STAT1, `OPC_RD_STAT2, `OPC_RD_STAT3: state_next = ST_READ;
        `OPC_WR_STAT1, `OPC_WR_STAT2, `OPC_WR_STAT3: begin
          // refused writes simply run out as an ignored frame
          if (write_latch && !op_in_progress && wr_allowed) state_next = ST_WRSTAT;
        end
        `OPC_PAGE_PROG, `OPC_SEC_PROG: begin
          if (write_latch && !op_in_progress) state_next = ST_PROG;
        end
        `OPC_ERASE_4K, `OPC_ERASE_32K, `OPC_ERASE_64K, `OPC_SEC_ERASE: begin
          if (write_latch && !op_in_progress) state_next = ST_ERASE;
        end
        `OPC_CHIP_ERASE1, `OPC_CHIP_ERASE2: begin
          if (write_latch && !op_in_progress) state_next = ST_CHIPER;
        end
        default: state_next = ST_IGNORE;
      endcase
    end
  end

  // frame state: reset by select high, so no clock edge is needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_OPCODE;
      rd_sel_reg <= 2'd0;
      wr_opc_reg <= 8'h00;
    end else if (sync_reg.cs_b) begin
      state_reg <= ST_OPCODE;
    end else begin
      state_reg <= state_next;
      if (byte_done && state_reg == ST_OPCODE) begin
        wr_opc_reg <= byte_in;
        rd_sel_reg <= (byte_in == `OPC_RD_STAT1) ? 2'd1 :
                      (byte_in == `OPC_RD_STAT2) ? 2'd2 : 2'd3;
      end
    end
  end

  // bit and byte counting, data capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= 8'h00;
      bit_cnt <= 3'd0;
      byte_cnt <= 3'd0;
      data0_reg <= 8'h00;
      data1_reg <= 8'h00;
    end else if (sync_reg.cs_b) begin
      bit_cnt <= 3'd0;
      byte_cnt <= 3'd0;
    end else if (rise) begin
      shift_reg <= byte_in;
      bit_cnt <= bit_cnt + 3'd1;
      if (byte_done && state_reg != ST_OPCODE) begin
        if (byte_cnt != 3'd7) byte_cnt <= byte_cnt + 3'd1;
        if (byte_cnt == 3'd0) data0_reg <= byte_in;
        if (byte_cnt == 3'd1) data1_reg <= byte_in;
      end
    end
  end

  // serial output: new bit on each falling clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      out_idx <= 3'd7;
      snap_reg <= 8'h00;
    end else if (sync_reg.cs_b) begin
      so_oe <= 1'b0;
      out_idx <= 3'd7;
    end else if (fall && state_reg == ST_READ) begin
      so_oe <= 1'b1;
      out_idx <= out_idx - 3'd1; // wraps from 0 back to 7
      if (out_idx == 3'd7) begin
        snap_reg <= stat_view; // fresh copy per repetition
        so <= stat_view[7];
      end else begin
        so <= snap_reg[out_idx];
      end
    end
  end

  // status bits: only writable ones change, resets restore defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat1_reg <= 6'h00; // locks back to 00
      stat2_reg <= 8'h00;
      stat3_reg <= `STAT3_RESET;
    end else if (busy_start && state_reg == ST_WRSTAT) begin
      unique case (wr_opc_reg)
        `OPC_WR_STAT1: begin
          stat1_reg <= data0_reg[7:2]; // latch and busy untouched
          if (byte_cnt == 3'd2) begin
            stat2_reg <= (stat2_reg & ~`STAT2_RW_MASK) | (data1_reg & `STAT2_RW_MASK);
          end
        end
        `OPC_WR_STAT2: stat2_reg <= (stat2_reg & ~`STAT2_RW_MASK) | (data0_reg & `STAT2_RW_MASK);
        default: stat3_reg <= (stat3_reg & ~`STAT3_RW_MASK) | (data0_reg & `STAT3_RW_MASK);
      endcase
    end
  end

  // busy timer for the self-timed cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= 16'd0;
      op_in_progress <= 1'b0;
      busy_from_prog <= 1'b0;
    end else if (busy_start) begin
      busy_cnt <= busy_len;
      op_in_progress <= 1'b1;
      busy_from_prog <= 1'b1;
    end else if (busy_cnt != 16'd0) begin
      busy_cnt <= busy_cnt - 16'd1;
      op_in_progress <= busy_cnt != 16'd1; // falls at the end
    end else begin
      busy_from_prog <= 1'b0;
    end
  end

  // write latch: cleared by disable, end of operation or abort
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_latch <= 1'b0;
    end else if (byte_done && state_reg == ST_OPCODE && byte_in == `OPC_WR_DISABLE) begin
      write_latch <= 1'b0;
    end else if (byte_done && state_reg == ST_OPCODE && byte_in == `OPC_WR_ENABLE) begin
      write_latch <= 1'b1;
    end else if (cs_rise && !frame_ok && state_reg inside {ST_WRSTAT, ST_PROG,
                 ST_ERASE, ST_CHIPER}) begin
      write_latch <= 1'b0; // abort after full opcode
    end else if (busy_from_prog && busy_cnt == 16'd1) begin
      write_latch <= 1'b0;
    end
  end

  // field views of the status bits
  assign status_lock_lo = stat1_reg[5];
  assign status_lock_hi = stat2_reg[`STAT2_LOCK_HI_BIT];
  assign output_strength = stat3_reg[`STAT3_STRENGTH_LSB +: 2];
  assign protect = '{protect_invert: stat2_reg[`STAT2_INVERT_BIT],
                     protect_granularity_sel: stat1_reg[4],
                     protect_top_bottom_sel: stat1_reg[3],
                     protect_amount: stat1_reg[2:0]};

  property p_latch_gate;
    @(posedge clk) disable iff (!rst_b)
      byte_done && state_reg == ST_OPCODE && !write_latch && byte_in == `OPC_PAGE_PROG
      |=> state_reg == ST_IGNORE;
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("program taken without latch");

  property p_hw_protect;
    @(posedge clk) disable iff (!rst_b)
      byte_done && state_reg == ST_OPCODE && locks == 2'b01 && !sync_reg.wp_b
      |=> state_reg != ST_WRSTAT;
  endproperty
  a_hw_protect: assert property (p_hw_protect) else $error("write accepted while pin low");

  property p_lockdown;
    @(posedge clk) disable iff (!rst_b)
      locks == 2'b10 |=> $stable(stat1_reg) && $stable(stat2_reg) && $stable(stat3_reg);
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("status changed in lock-down");

  property p_release;
    @(posedge clk) disable iff (!rst_b)
      cs_rise |=> !so_oe ##1 !so_oe;
  endproperty
  a_release: assert property (p_release) else $error("output driven after deselect");

  property p_wrap;
    @(posedge clk) disable iff (!rst_b)
      fall && state_reg == ST_READ && out_idx == 3'd0 |=> out_idx == 3'd7;
  endproperty
  a_wrap: assert property (p_wrap) else $error("read did not wrap to bit 7");

  property p_partial_keep;
    @(posedge clk) disable iff (!rst_b)
      cs_rise && state_reg == ST_OPCODE && write_latch |=> write_latch;
  endproperty
  a_partial_keep: assert property (p_partial_keep) else $error("latch lost on partial opcode");

  property p_abort_clear;
    @(posedge clk) disable iff (!rst_b)
      cs_rise && !frame_ok && state_reg inside {ST_PROG, ST_ERASE} |=> !write_latch;
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("latch kept after abort");

  property p_busy_hold;
    @(posedge clk) disable iff (!rst_b)
      busy_start |=> op_in_progress [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_end;
    @(posedge clk) disable iff (!rst_b)
      $fell(op_in_progress) |-> busy_cnt == 16'd0 && !write_latch;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended out of step");
endmodule // flash_status_protect_regs

// file: verification/flash_status_protect_regs_tb.sv
module flash_status_protect_regs_tb;
  import flash_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_level = 1'b1;
  spi_pins_t pins;
  logic so, so_oe, write_latch, op_in_progress, status_lock_hi, status_lock_lo;
  logic [1:0] output_strength;
  protect_t protect;
  logic rx_valid;
  logic [63:0] rx_word;
  logic [63:0] exp_q[$];
  int bits_q[$];
  int fail_count = 0;
  int compares = 0;
  logic [31:0] seed = 32'ha6a2;
  logic [7:0] rnd;
  int nb;
  logic fb;
  always #2 clk = ~clk;
  // long busy so a single poll frame sees busy high and then low
  flash_status_protect_regs #(.WRSTAT_CYCLES(600), .PROG_CYCLES(100)) flash_status_protect_regs_i (
    .clk(clk), .rst_b(rst_b), .pins(pins), .so(so), .so_oe(so_oe),
    .write_latch(write_latch), .op_in_progress(op_in_progress),
    .output_strength(output_strength), .status_lock_hi(status_lock_hi),
    .status_lock_lo(status_lock_lo), .protect(protect));
  spi_host_model spi_host_model_i (.clk(clk), .wp_level(wp_level), .so(so), .so_oe(so_oe),
    .pins(pins),
    .rx_valid(rx_valid), .rx_word(rx_word));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    check("queue left", 64'(exp_q.size()), 64'h0);
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for the internal cycle to finish
  task automatic wait_idle();
    int n;
    n = 0;
    while (op_in_progress !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic cmd(input logic [63:0] tx, input int nbits);
    spi_host_model_i.frame(tx, nbits);
    wait_idle();
  endtask
  // read frame: the note goes on the queue before the frame starts
  task automatic rd(input logic [7:0] opc, input int n, input logic [63:0] exp);
    exp_q.push_back(exp);
    bits_q.push_back(n);
    spi_host_model_i.frame({opc, 56'h0}, 8 + n);
  endtask
  // monitor: opcode-time bits are masked off, only read bits are judged
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0) begin
      check("so data", rx_word & ((64'h1 << bits_q[0]) - 64'h1), exp_q[0]);
      void'(exp_q.pop_front());
      void'(bits_q.pop_front());
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check("latch", write_latch, 64'h0);
    check("strength", output_strength, 64'h3);
    check("locks", {status_lock_hi, status_lock_lo}, 64'h0);
    rd(8'h15, 16, 64'h6060);
    rd(8'h15, 3, 64'h3);
    check("so_oe", so_oe, 64'h0);
    cmd({8'h11, 8'h00, 48'h0}, 16);
    check("strength", output_strength, 64'h3);
    cmd({8'h06, 56'h0}, 8);
    check("latch", write_latch, 64'h1);
    rd(8'h05, 8, 64'h02);
    seed = lfsr(seed);
    spi_host_model_i.frame({8'h06, 56'h0}, int'(seed % 7) + 1);
    check("latch", write_latch, 64'h1);
    seed = lfsr(seed);
    rnd = seed[7:0];
    spi_host_model_i.frame({8'h11, rnd, 48'h0}, 16);
    spi_host_model_i.poll(nb, fb);
    check("busy first", fb, 64'h1);
    check("poll bytes", {63'h0, (nb > 1 && nb < 32)}, 64'h1);
    check("latch", write_latch, 64'h0);
    wait_idle();
    rd(8'h15, 8, 64'(rnd));
    check("strength", output_strength, 64'(rnd[6:5]));
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h02, 8'h00, 48'h0}, 16);
    check("latch", write_latch, 64'h0);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h04, 56'h0}, 8);
    check("latch", write_latch, 64'h0);
    spi_host_model_i.frame({8'h02, 24'h0, 8'h5a, 24'h0}, 40);
    check("busy", op_in_progress, 64'h0);
    cmd({8'h06, 56'h0}, 8);
    spi_host_model_i.frame({8'h20, 24'h0, 32'h0}, 32);
    check("busy", op_in_progress, 64'h1);
    wait_idle();
    check("latch", write_latch, 64'h0);
    cmd({8'h06, 56'h0}, 8);
    spi_host_model_i.frame({8'h60, 56'h0}, 8);
    check("busy", op_in_progress, 64'h1);
    wait_idle();
    check("latch", write_latch, 64'h0);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h01, 8'h83, 48'h0}, 16);
    check("latch", write_latch, 64'h0);
    check("lock lo", status_lock_lo, 64'h1);
    wp_level = 1'b0;
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h11, ~rnd, 48'h0}, 16);
    check("strength", output_strength, 64'(rnd[6:5]));
    wp_level = 1'b1;
    cmd({8'h11, ~rnd, 48'h0}, 16);
    check("strength", output_strength, {62'h0, ~rnd[6:5]});
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h01, 8'h7c, 8'hc5, 40'h0}, 24);
    check("locks", {status_lock_hi, status_lock_lo}, 64'h2);
    check("protect", protect, 64'h3f);
    rd(8'h35, 8, 64'h41);
    rd(8'h05, 8, 64'h7c);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h11, rnd, 48'h0}, 16);
    check("strength", output_strength, {62'h0, ~rnd[6:5]});
    // a reset stands for the power cycle out of lock-down
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check("locks", {status_lock_hi, status_lock_lo}, 64'h0);
    check("latch", write_latch, 64'h0);
    test_done();
  end
endmodule // flash_status_protect_regs_tb

// file: verification/spi_host_model.sv
// spi host for the status block: mode 0, sck still while cs_b is high
module spi_host_model
  import flash_status_pkg::*;
(
  input wire logic clk,
  input wire logic wp_level,
  input wire logic so,
  input wire logic so_oe,
  output spi_pins_t pins,
  output logic rx_valid,
  output logic [63:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle pins; si idles at the inverse of its last bit so no stale value shows
  initial begin
    pins = '{cs_b: 1'b1, sck: 1'b0, si: 1'b0, wp_b: 1'b1};
    rx_valid = 1'b0;
    rx_word = '0;
  end
  // protect pin follows the bench level, changed on the falling edge
  always @(negedge clk) begin
    pins.wp_b <= wp_level;
  end
  // one bit: si set while sck low, so taken at the rise, six cycles a half
  task automatic bit_io(input logic b, output logic r);
    pins.si = b;
    repeat (6) @(negedge clk);
    pins.sck = 1'b1;
    // a released line shows the inverse of its last level, never a stale bit
    r = so_oe ? so : ~so;
    repeat (6) @(negedge clk);
    pins.sck = 1'b0;
  endtask
  task automatic start();
    @(negedge clk);
    pins.cs_b = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // raising cs_b ends any frame, even mid byte
  task automatic stop();
    repeat (6) @(negedge clk);
    pins.cs_b = 1'b1;
    pins.si = ~pins.si;
    repeat (8) @(negedge clk);
  endtask
  // sends tx from bit 63 down, msb first, and collects so at each rise
  task automatic frame(input logic [63:0] tx, input int nbits);
    logic r;
    logic [63:0] acc;
    acc = '0;
    start();
    for (int i = 0; i < nbits; i++) begin
      bit_io(tx[63-i], r);
      acc = {acc[62:0], r};
    end
    rx_word = acc;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    stop();
  endtask
  // keeps clocking first status byte in one frame until busy falls
  task automatic poll(output int nbytes, output logic first_busy);
    logic r;
    logic [7:0] b;
    logic [7:0] opc;
    opc = 8'h05;
    start();
    for (int k = 0; k < 8; k++) bit_io(opc[7 - k], r);
    nbytes = 0;
    b = 8'h01;
    first_busy = 1'b0;
    while (b[0] === 1'b1 && nbytes < 32) begin
      for (int k = 0; k < 8; k++) begin
        bit_io(1'b0, r);
        b = {b[6:0], r};
      end
      if (nbytes == 0) first_busy = b[0];
      nbytes++;
    end
    stop();
  endtask
endmodule // spi_host_model
